//--- csbc_pkg.sv
// Package of constants for the status bus command controller.
package csbc_pkg;
  localparam int STATUS_W = 3;
  localparam logic [2:0] ST_IRQ_ACK = 3'h0;
  localparam logic [2:0] ST_IO_READ = 3'h1;
  localparam logic [2:0] ST_IO_WRITE = 3'h2;
  localparam logic [2:0] ST_HALT = 3'h3;
  localparam logic [2:0] ST_CODE_FETCH = 3'h4;
  localparam logic [2:0] ST_MEM_READ = 3'h5;
  localparam logic [2:0] ST_MEM_WRITE = 3'h6;
  localparam logic [2:0] ST_PASSIVE = 3'h7;
  localparam logic [2:0] CTRL_SYNC_INIT = 3'h2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int GRANT_DELAY_NS = 105;
  localparam int GRANT_DELAY_CYC = (GRANT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GRANT_CNT_W = 5;
  typedef enum logic [2:0] {
    CSBC_IDLE,
    CSBC_ADDR,
    CSBC_CMD,
    CSBC_DATA
  } csbc_phase_e;
endpackage : csbc_pkg

//--- csbc_sync2.sv
// Two-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module csbc_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : csbc_sync2
`default_nettype wire

//--- csbc_grant_timer.sv
// Grant qualification timer that enables commands a fixed time after grant.
`timescale 1ns/1ps
`default_nettype none
module csbc_grant_timer #(
  parameter int DELAY_CYC = csbc_pkg::GRANT_DELAY_CYC,
  parameter int CNT_W = csbc_pkg::GRANT_CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Grant in and qualified enable out
  input wire logic grant,
  output logic enabled
);
  logic [CNT_W-1:0] count;

  // Any loss of grant restarts the wait; enable is never early.
  always_ff @(posedge clk) begin
    if (!reset_n || !grant) begin
      count <= '0;
      enabled <= 1'b0;
    end else if (count < CNT_W'(DELAY_CYC - 1)) begin
      count <= count + CNT_W'(1);
    end else begin
      enabled <= 1'b1;
    end
  end
endmodule : csbc_grant_timer
`default_nettype wire

//--- csbc_controller.sv
// Status bus command controller: decodes cycle status into bus commands.
`timescale 1ns/1ps
`default_nettype none
module csbc_controller (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Processor status and straps
  input wire logic [2:0] CYCLE_STATUS_IN,
  input wire logic IO_BUS_MODE_STRAP,
  input wire logic BUS_GRANT_N,
  input wire logic COMMAND_GATE,
  // Command strobes
  output logic MEM_READ_N,
  output logic MEM_WRITE_N,
  output logic EARLY_MEM_WRITE_N,
  output logic IO_READ_N,
  output logic IO_WRITE_N,
  output logic EARLY_IO_WRITE_N,
  output logic IRQ_ACK_N,
  // Command output enables, high while driving
  output logic MEM_CMD_OE,
  output logic IO_CMD_OE,
  // Transceiver and latch controls
  output logic ADDR_LATCH_STROBE,
  output logic TRANSFER_DIRECTION,
  output logic SYSTEM_DATA_ENABLE,
  output logic CASCADE_ENABLE,
  output logic PERIPH_DATA_ENABLE_N
);
  logic [2:0] status_sync;
  logic [2:0] strap_grant_gate;
  logic io_mode;
  logic grant;
  logic gate;
  logic grant_ok;
  logic [2:0] status_q;
  logic [2:0] status_prev;
  logic status_active;
  logic cycle_start;
  logic first_ack;
  logic cmd_is_io;
  logic allowed;
  logic is_write;
  logic cmd_window;
  logic data_window;
  logic want_ack;
  logic want_io_read;
  logic want_io_write;
  logic want_mem_read;
  logic want_mem_write;
  logic ack_start;
  csbc_pkg::csbc_phase_e phase;
  csbc_pkg::csbc_phase_e next_phase;

  // Pin inputs pass two flops; passive is the reset image of the status.
  csbc_sync2 #(.WIDTH(csbc_pkg::STATUS_W), .INIT(csbc_pkg::ST_PASSIVE)) u_sync_status (
    .clk(CLK),
    .reset_n(RESET_N),
    .d(CYCLE_STATUS_IN),
    .q(status_sync)
  );

  // Reset image is system mode, no grant and gate off, so nothing drives early.
  csbc_sync2 #(.WIDTH(3), .INIT(csbc_pkg::CTRL_SYNC_INIT)) u_sync_ctrl (
    .clk(CLK),
    .reset_n(RESET_N),
    .d({IO_BUS_MODE_STRAP, BUS_GRANT_N, COMMAND_GATE}),
    .q(strap_grant_gate)
  );

  assign io_mode = strap_grant_gate[2];
  assign grant = !strap_grant_gate[1];
  assign gate = strap_grant_gate[0];

  // Grant is qualified no sooner than 105 ns after it goes low.
  csbc_grant_timer u_grant_timer (
    .clk(CLK),
    .reset_n(RESET_N),
    .grant(grant),
    .enabled(grant_ok)
  );

  function automatic logic is_passive(input logic [2:0] st);
    return st == csbc_pkg::ST_PASSIVE;
  endfunction : is_passive

  function automatic logic is_io_cmd(input logic [2:0] st);
    return st == csbc_pkg::ST_IO_READ || st == csbc_pkg::ST_IO_WRITE;
  endfunction : is_io_cmd

  assign status_active = !is_passive(status_sync);
  // A new cycle starts when status leaves passive.
  assign cycle_start = status_active && is_passive(status_prev);
  assign ack_start = cycle_start && status_sync == csbc_pkg::ST_IRQ_ACK;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      status_prev <= csbc_pkg::ST_PASSIVE;
    end else begin
      status_prev <= status_sync;
    end
  end

  // Status is captured at each cycle start, gate or not, including halt cycles.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      status_q <= csbc_pkg::ST_PASSIVE;
    end else if (cycle_start) begin
      status_q <= status_sync;
    end
  end

  // Phase sequence: address, command, data; passive closes it.
  always_comb begin
    next_phase = phase;
    case (phase)
      csbc_pkg::CSBC_IDLE: begin
        if (cycle_start) begin
          next_phase = csbc_pkg::CSBC_ADDR;
        end
      end
      csbc_pkg::CSBC_ADDR: begin
        next_phase = status_active ? csbc_pkg::CSBC_CMD : csbc_pkg::CSBC_IDLE;
      end
      csbc_pkg::CSBC_CMD: begin
        next_phase = status_active ? csbc_pkg::CSBC_DATA : csbc_pkg::CSBC_IDLE;
      end
      csbc_pkg::CSBC_DATA: begin
        if (!status_active) begin
          next_phase = csbc_pkg::CSBC_IDLE;
        end
      end
      default: begin
        next_phase = csbc_pkg::CSBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      phase <= csbc_pkg::CSBC_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // Cascade only on the first of each pair of acknowledge cycles.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      first_ack <= 1'b1;
    end else if (cycle_start) begin
      if (ack_start) begin
        first_ack <= !first_ack;
      end else begin
        first_ack <= 1'b1;
      end
    end
  end

  assign cmd_is_io = is_io_cmd(status_q) || status_q == csbc_pkg::ST_IRQ_ACK;
  // I/O commands bypass grant in I/O mode.
  assign allowed = gate && ((io_mode && cmd_is_io) || grant_ok);
  assign is_write = status_q == csbc_pkg::ST_MEM_WRITE || status_q == csbc_pkg::ST_IO_WRITE;
  // Strobes need an enabled, still active cycle past its address phase.
  assign cmd_window = allowed && status_active && next_phase inside {csbc_pkg::CSBC_CMD, csbc_pkg::CSBC_DATA};
  assign data_window = allowed && status_active && next_phase == csbc_pkg::CSBC_DATA;
  // One decode of the captured status feeds every strobe.
  assign want_ack = status_q == csbc_pkg::ST_IRQ_ACK;
  assign want_io_read = status_q == csbc_pkg::ST_IO_READ;
  assign want_io_write = status_q == csbc_pkg::ST_IO_WRITE;
  assign want_mem_read = status_q == csbc_pkg::ST_CODE_FETCH || status_q == csbc_pkg::ST_MEM_READ;
  assign want_mem_write = status_q == csbc_pkg::ST_MEM_WRITE;

  // Every output below leaves a flop on the one clock.
  // Memory commands are driven only once the grant is qualified.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      MEM_CMD_OE <= 1'b0;
    end else begin
      MEM_CMD_OE <= grant_ok;
    end
  end

  // I/O commands ignore the grant in I/O bus mode.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      IO_CMD_OE <= 1'b0;
    end else begin
      IO_CMD_OE <= io_mode || grant_ok;
    end
  end

  // Latch strobe: one cycle, falling edge latches the address.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ADDR_LATCH_STROBE <= 1'b0;
    end else begin
      ADDR_LATCH_STROBE <= gate && cycle_start;
    end
  end

  // Direction set from the captured status, held until cycle end.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      TRANSFER_DIRECTION <= 1'b0;
    end else begin
      TRANSFER_DIRECTION <= gate && phase != csbc_pkg::CSBC_IDLE && status_active && is_write;
    end
  end

  // Memory read opens with the command phase; code fetch reads the same way.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      MEM_READ_N <= 1'b1;
    end else begin
      MEM_READ_N <= !(cmd_window && want_mem_read);
    end
  end

  // I/O read opens with the command phase.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      IO_READ_N <= 1'b1;
    end else begin
      IO_READ_N <= !(cmd_window && want_io_read);
    end
  end

  // Acknowledge is timed as a read so the vector is on the bus in time.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      IRQ_ACK_N <= 1'b1;
    end else begin
      IRQ_ACK_N <= !(cmd_window && want_ack);
    end
  end

  // Early memory write shares the read timing, giving slow targets a head start.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      EARLY_MEM_WRITE_N <= 1'b1;
    end else begin
      EARLY_MEM_WRITE_N <= !(cmd_window && want_mem_write);
    end
  end

  // Early I/O write leads the normal I/O write by one phase.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      EARLY_IO_WRITE_N <= 1'b1;
    end else begin
      EARLY_IO_WRITE_N <= !(cmd_window && want_io_write);
    end
  end

  // Normal memory write waits for the data phase, when write data is stable.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      MEM_WRITE_N <= 1'b1;
    end else begin
      MEM_WRITE_N <= !(data_window && want_mem_write);
    end
  end

  // Normal I/O write waits for the data phase as well.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      IO_WRITE_N <= 1'b1;
    end else begin
      IO_WRITE_N <= !(data_window && want_io_write);
    end
  end

  // System data enable in the data phase; halt and passive move no data.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      SYSTEM_DATA_ENABLE <= 1'b0;
    end else begin
      SYSTEM_DATA_ENABLE <= data_window && status_q != csbc_pkg::ST_HALT && !(io_mode && cmd_is_io);
    end
  end

  // The dual pin enables the I/O bus transceivers only in I/O bus mode.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      PERIPH_DATA_ENABLE_N <= 1'b1;
    end else begin
      PERIPH_DATA_ENABLE_N <= !(data_window && io_mode && cmd_is_io);
    end
  end

  // Cascade enable rides with the latch strobe in system mode only.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      CASCADE_ENABLE <= 1'b0;
    end else begin
      CASCADE_ENABLE <= gate && !io_mode && ack_start && first_ack;
    end
  end
endmodule : csbc_controller
`default_nettype wire

//--- csbc_cpu_model.sv
// Processor status and bus arbiter model that drives the controller's status and grant inputs.
`timescale 1ns/1ps
`default_nettype none
module csbc_cpu_model (
  // Clock
  input wire logic clk,
  // Status and grant toward the controller
  output logic [2:0] status,
  output logic grant_n
);
  initial begin
    status = csbc_pkg::ST_PASSIVE;
    grant_n = 1'h1;
  end
  // Status changes only after a falling edge, clear of the sampling edge.
  task automatic put(input logic [2:0] code);
    @(negedge clk) status = code;
  endtask : put
  // The arbiter grants only while the shared bus is free.
  task automatic arbit(input logic free);
    @(negedge clk) grant_n = !free;
  endtask : arbit
endmodule : csbc_cpu_model
`default_nettype wire

//--- csbc_controller_sva.sv
// Assertion checker bound to the status bus command controller.
`timescale 1ns/1ps
`default_nettype none
module csbc_controller_sva (
  // Clock, reset and inputs
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [2:0] CYCLE_STATUS_IN,
  input wire logic IO_BUS_MODE_STRAP,
  input wire logic BUS_GRANT_N,
  input wire logic COMMAND_GATE,
  // Command strobes
  input wire logic MEM_READ_N,
  input wire logic MEM_WRITE_N,
  input wire logic EARLY_MEM_WRITE_N,
  input wire logic IO_READ_N,
  input wire logic IO_WRITE_N,
  input wire logic EARLY_IO_WRITE_N,
  input wire logic IRQ_ACK_N,
  // Enables and controls
  input wire logic MEM_CMD_OE,
  input wire logic IO_CMD_OE,
  input wire logic ADDR_LATCH_STROBE,
  input wire logic TRANSFER_DIRECTION,
  input wire logic SYSTEM_DATA_ENABLE,
  input wire logic CASCADE_ENABLE,
  input wire logic PERIPH_DATA_ENABLE_N
);
  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] s3;
  logic [6:0] cmd;
  logic start;
  // Mirrors the two-flop input synchroniser so cycle starts line up.
  always_ff @(posedge CLK) begin
    s1 <= CYCLE_STATUS_IN;
    s2 <= s1;
    s3 <= s2;
  end
  assign cmd = {MEM_READ_N, MEM_WRITE_N, EARLY_MEM_WRITE_N, IO_READ_N, IO_WRITE_N, EARLY_IO_WRITE_N, IRQ_ACK_N};
  assign start = s2 != 3'h7 && s3 == 3'h7;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  property p_ale_pulse; $rose(ADDR_LATCH_STROBE) |=> !ADDR_LATCH_STROBE; endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("latch strobe too long");
  property p_ale_each; start && COMMAND_GATE && $past(COMMAND_GATE, 4) |-> ##[0:1] ADDR_LATCH_STROBE; endproperty
  a_ale_each: assert property (p_ale_each) else $error("latch strobe missing");
  property p_gate; (!COMMAND_GATE) [*4] |-> cmd == 7'h7F && !ADDR_LATCH_STROBE && !SYSTEM_DATA_ENABLE; endproperty
  a_gate: assert property (p_gate) else $error("output active with gate low");
  property p_grant_off; (!IO_BUS_MODE_STRAP && BUS_GRANT_N) [*5] |-> !MEM_CMD_OE && !IO_CMD_OE; endproperty
  a_grant_off: assert property (p_grant_off) else $error("commands driven without grant");
  property p_grant_delay; $fell(BUS_GRANT_N) && !IO_BUS_MODE_STRAP |=> !MEM_CMD_OE [*8] ##[3:8] MEM_CMD_OE; endproperty
  a_grant_delay: assert property (p_grant_delay) else $error("grant delay wrong");
  property p_io_oe; (IO_BUS_MODE_STRAP && COMMAND_GATE) [*4] |-> IO_CMD_OE; endproperty
  a_io_oe: assert property (p_io_oe) else $error("io commands not driven");
  property p_mem_early; $fell(EARLY_MEM_WRITE_N) |-> MEM_WRITE_N && TRANSFER_DIRECTION ##1 !MEM_WRITE_N; endproperty
  a_mem_early: assert property (p_mem_early) else $error("memory write order wrong");
  property p_io_early; $fell(EARLY_IO_WRITE_N) |-> IO_WRITE_N ##1 !IO_WRITE_N; endproperty
  a_io_early: assert property (p_io_early) else $error("io write order wrong");
  property p_read_den; $fell(MEM_READ_N) |-> !SYSTEM_DATA_ENABLE && !TRANSFER_DIRECTION ##1 SYSTEM_DATA_ENABLE; endproperty
  a_read_den: assert property (p_read_den) else $error("read data enable wrong");
  property p_cascade; CASCADE_ENABLE |-> ADDR_LATCH_STROBE && !IO_BUS_MODE_STRAP; endproperty
  a_cascade: assert property (p_cascade) else $error("cascade enable misplaced");
  property p_end; (s2 == 3'h7) [*3] |-> cmd == 7'h7F; endproperty
  a_end: assert property (p_end) else $error("strobe left on when passive");
  c_cascade: cover property (CASCADE_ENABLE);
  c_mem_write: cover property (!MEM_WRITE_N);
  c_io_bus: cover property (!PERIPH_DATA_ENABLE_N);
endmodule : csbc_controller_sva
bind csbc_controller csbc_controller_sva SVA (.*);
`default_nettype wire

//--- csbc_controller_test.sv
// Self-checking testbench for the status bus command controller.
`timescale 1ns/1ps
`default_nettype none
module csbc_controller_test;
  logic CLK;
  logic RESET_N;
  logic IO_BUS_MODE_STRAP;
  logic COMMAND_GATE;
  logic [2:0] CYCLE_STATUS_IN;
  logic BUS_GRANT_N;
  logic MEM_READ_N, MEM_WRITE_N, EARLY_MEM_WRITE_N, IO_READ_N, IO_WRITE_N, EARLY_IO_WRITE_N, IRQ_ACK_N;
  logic MEM_CMD_OE, IO_CMD_OE, ADDR_LATCH_STROBE, TRANSFER_DIRECTION;
  logic SYSTEM_DATA_ENABLE, CASCADE_ENABLE, PERIPH_DATA_ENABLE_N;
  wire logic [6:0] strobes;
  int miscompares;
  int checked;
  logic ack2;
  assign strobes = {MEM_READ_N, MEM_WRITE_N, EARLY_MEM_WRITE_N, IO_READ_N, IO_WRITE_N, EARLY_IO_WRITE_N, IRQ_ACK_N};
  csbc_controller DUT (.*);
  csbc_cpu_model CPU (.clk(CLK), .status(CYCLE_STATUS_IN), .grant_n(BUS_GRANT_N));
  initial begin
    CLK = 1'h0;
    forever #5 CLK = !CLK;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // One whole machine cycle; expectations follow the decode table and the enables.
  task automatic bus_cycle(input logic [2:0] code);
    logic io, en, mc, pd;
    logic [6:0] e;
    logic [3:0] ale;
    logic [3:0] cascade_enable;
    io = code < 3'h4;
    en = COMMAND_GATE && (io && IO_BUS_MODE_STRAP || !BUS_GRANT_N) && code != 3'h3;
    pd = en && io && IO_BUS_MODE_STRAP;
    mc = code == 3'h0 && !ack2 && !IO_BUS_MODE_STRAP && COMMAND_GATE;
    ack2 = code == 3'h0 ? !ack2 : 1'h0;
    e = 7'h7F;
    if (en) begin
      case (code)
        3'h0: e = 7'h7E;
        3'h1: e = 7'h77;
        3'h2: e = 7'h79;
        3'h6: e = 7'h4F;
        default: e = 7'h3F;
      endcase
    end
    ale = 4'h0;
    cascade_enable = 4'h0;
    CPU.put(code);
    repeat (6) begin
      @(negedge CLK);
      ale = ale + {3'h0, ADDR_LATCH_STROBE};
      cascade_enable = cascade_enable + {3'h0, CASCADE_ENABLE};
    end
    chk({1'h0, strobes}, {1'h0, e});
    chk({4'h0, ale}, {7'h0, COMMAND_GATE});
    chk({4'h0, cascade_enable}, {7'h0, mc});
    chk({7'h0, SYSTEM_DATA_ENABLE}, {7'h0, en && !pd});
    chk({7'h0, PERIPH_DATA_ENABLE_N}, {7'h0, !pd});
    if (en) chk({7'h0, TRANSFER_DIRECTION}, {7'h0, code == 3'h2 || code == 3'h6});
    CPU.put(csbc_pkg::ST_PASSIVE);
    repeat (5) @(negedge CLK);
    chk({1'h0, strobes}, 8'h7F);
  endtask : bus_cycle
  task automatic sys_decode();
    CPU.arbit(1'h1);
    repeat (20) @(negedge CLK);
    for (int c = 0; c < 7; c++) bus_cycle(c[2:0]);
    bus_cycle(3'h0);
    bus_cycle(3'h0);
  endtask : sys_decode
  task automatic grant_wait();
    CPU.arbit(1'h0);
    repeat (4) @(negedge CLK);
    chk({7'h0, MEM_CMD_OE}, 8'h00);
    chk({7'h0, IO_CMD_OE}, 8'h00);
    bus_cycle(3'h5);
    bus_cycle(3'h2);
    CPU.arbit(1'h1);
    repeat (8) @(negedge CLK);
    chk({7'h0, MEM_CMD_OE}, 8'h00);
    repeat (8) @(negedge CLK);
    chk({7'h0, MEM_CMD_OE}, 8'h01);
  endtask : grant_wait
  // The strap is only moved while the status is passive.
  task automatic io_mode();
    CPU.arbit(1'h0);
    IO_BUS_MODE_STRAP = 1'h1;
    repeat (4) @(negedge CLK);
    chk({7'h0, IO_CMD_OE}, 8'h01);
    chk({7'h0, MEM_CMD_OE}, 8'h00);
    for (int c = 0; c < 3; c++) bus_cycle(c[2:0]);
    bus_cycle(3'h5);
    CPU.arbit(1'h1);
    repeat (16) @(negedge CLK);
    bus_cycle(3'h5);
  endtask : io_mode
  task automatic gate_off();
    COMMAND_GATE = 1'h0;
    repeat (4) @(negedge CLK);
    bus_cycle(3'h6);
    bus_cycle(3'h1);
    COMMAND_GATE = 1'h1;
    repeat (4) @(negedge CLK);
    bus_cycle(3'h1);
  endtask : gate_off
  initial begin
    RESET_N = 1'h0;
    IO_BUS_MODE_STRAP = 1'h0;
    COMMAND_GATE = 1'h1;
    miscompares = 0;
    checked = 0;
    ack2 = 1'h0;
    repeat (12) @(negedge CLK);
    RESET_N = 1'h1;
    repeat (3) @(negedge CLK);
    sys_decode();
    grant_wait();
    io_mode();
    gate_off();
    results();
  end
  // Far beyond the few hundred cycles that the scenarios need.
  initial begin
    #100000;
    miscompares++;
    results();
  end
endmodule : csbc_controller_test
`default_nettype wire
